// ### shared/irrc_regs.vh
// Constants for the interrupt remap request checker
`ifndef IRRC_REGS_VH
`define IRRC_REGS_VH

// Interrupt address window identifier in address bits 31:20
`define IRRC_IRQ_WINDOW_ID 12'hFEE

// Request address field positions
`define IRRC_ADDR_ID_HI 31
`define IRRC_ADDR_ID_LO 20
`define IRRC_ADDR_HANDLE_HI 19
`define IRRC_ADDR_HANDLE_LO 5
`define IRRC_ADDR_FORMAT 4
`define IRRC_ADDR_SUB_VALID 3
`define IRRC_ADDR_HANDLE15 2

// Request data field positions
`define IRRC_DATA_RSVD_HI 31
`define IRRC_DATA_RSVD_LO 16
`define IRRC_DATA_SUB_HI 15
`define IRRC_DATA_SUB_LO 0

// Fault reason codes
`define IRRC_FR_REQ_RSVD 8'h20
`define IRRC_FR_BOUNDS 8'h21
`define IRRC_FR_NOT_PRESENT 8'h22
`define IRRC_FR_TABLE_ERR 8'h23
`define IRRC_FR_ENTRY_RSVD 8'h24
`define IRRC_FR_LEGACY_BLOCK 8'h25
`define IRRC_FR_ID_FAIL 8'h26

// Output kinds
`define IRRC_KIND_OTHER 2'h0
`define IRRC_KIND_LEGACY 2'h1
`define IRRC_KIND_REMAP 2'h2

// Remap table entry layout (128 bits)
`define IRRC_E_PRESENT 0
`define IRRC_E_FAULT_DIS 1
`define IRRC_E_DST_MODE 2
`define IRRC_E_REDIR_HINT 3
`define IRRC_E_TRIG_MODE 4
`define IRRC_E_DLV_HI 7
`define IRRC_E_DLV_LO 5
`define IRRC_E_RSVD0_HI 15
`define IRRC_E_RSVD0_LO 12
`define IRRC_E_VEC_HI 23
`define IRRC_E_VEC_LO 16
`define IRRC_E_RSVD1_HI 31
`define IRRC_E_RSVD1_LO 24
`define IRRC_E_DEST_HI 63
`define IRRC_E_DEST_LO 32
`define IRRC_E_EXP_ID_HI 79
`define IRRC_E_EXP_ID_LO 64
`define IRRC_E_QUAL_HI 81
`define IRRC_E_QUAL_LO 80
`define IRRC_E_VERIFY_HI 83
`define IRRC_E_VERIFY_LO 82
`define IRRC_E_RSVD2_HI 127
`define IRRC_E_RSVD2_LO 84

// Requester verify types
`define IRRC_VERIFY_NONE 2'h0
`define IRRC_VERIFY_ID 2'h1
`define IRRC_VERIFY_BUS 2'h2

// Entry cache geometry
`define IRRC_CACHE_SLOT_BITS 4
`define IRRC_CACHE_DEPTH 16

`endif

// ### verif/irrc_asserts.sv
// Port-level assertions for the interrupt remap request checker
`timescale 1ns/100ps
module irrc_asserts (
  input wire MCLK,
  input wire RST,
  input wire REQ_VALID,
  input wire REQ_READY,
  input wire REQ_DWORD,
  input wire [31:0] REQ_ADDR,
  input wire [31:0] REQ_DATA,
  input wire REMAP_ENABLED_STATUS,
  input wire EXTENDED_IRQ_MODE_ENABLE,
  input wire LEGACY_FORMAT_ALLOWED,
  input wire COHERENT,
  input wire [16:0] TABLE_SIZE,
  input wire MEM_RD_VALID,
  input wire [63:0] MEM_RD_ADDR,
  input wire MEM_RD_NO_SNOOP,
  input wire MEM_RESP_VALID,
  input wire MEM_RESP_ERROR,
  input wire OUT_VALID,
  input wire [1:0] OUT_KIND,
  input wire OUT_TRIG_LEVEL,
  input wire FAULT_VALID,
  input wire [7:0] FAULT_REASON,
  input wire FAULT_QUALIFIED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire acc = REQ_VALID && REQ_READY;
  wire win = acc && REQ_DWORD && REQ_ADDR[31:20] == 12'hFEE;
  wire fmt0 = win && REMAP_ENABLED_STATUS && !REQ_ADDR[4];
  wire fmt1 = win && REMAP_ENABLED_STATUS && REQ_ADDR[4];
  wire bad_leg = EXTENDED_IRQ_MODE_ENABLE || !LEGACY_FORMAT_ALLOWED;
  wire [16:0] idx = {1'h0, REQ_ADDR[2], REQ_ADDR[19:5]};
  property p_other; acc && !win |=> OUT_VALID && OUT_KIND == 2'h0; endproperty
  a_other: assert property (p_other) else $error("plain write not passed");
  property p_off; win && !REMAP_ENABLED_STATUS |=> OUT_VALID && OUT_KIND == 2'h1; endproperty
  a_off: assert property (p_off) else $error("legacy handling missing");
  property p_block; fmt0 && bad_leg |=> FAULT_VALID && FAULT_REASON == 8'h25; endproperty
  a_block: assert property (p_block) else $error("legacy format not blocked");
  property p_pass; fmt0 && !bad_leg |=> OUT_VALID && OUT_KIND == 2'h1; endproperty
  a_pass: assert property (p_pass) else $error("legacy format not passed");
  property p_rsvd; fmt1 && REQ_ADDR[3] && REQ_DATA[31:16] != 16'h0 |=> FAULT_REASON == 8'h20;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved data not faulted");
  property p_bound; fmt1 && !REQ_ADDR[3] && idx >= TABLE_SIZE |=> FAULT_VALID && FAULT_REASON == 8'h21;
  endproperty
  a_bound: assert property (p_bound) else $error("index bound missed");
  property p_snoop; MEM_RD_VALID |-> MEM_RD_NO_SNOOP == !COHERENT && MEM_RD_ADDR[3:0] == 4'h0;
  endproperty
  a_snoop: assert property (p_snoop) else $error("table read attributes wrong");
  property p_err; MEM_RESP_VALID && MEM_RESP_ERROR |-> ##[1:2] FAULT_VALID && FAULT_REASON == 8'h23;
  endproperty
  a_err: assert property (p_err) else $error("read error not faulted");
  property p_trig; OUT_VALID && OUT_KIND == 2'h2 |-> OUT_TRIG_LEVEL; endproperty
  a_trig: assert property (p_trig) else $error("trigger level low");
  property p_qual; FAULT_VALID |-> FAULT_QUALIFIED == (FAULT_REASON inside {8'h22, 8'h24, 8'h26});
  endproperty
  a_qual: assert property (p_qual) else $error("qualified flag wrong");
  c_remap: cover property (OUT_VALID && OUT_KIND == 2'h2);
  c_qual: cover property (FAULT_VALID && FAULT_QUALIFIED);
  c_fetch: cover property (MEM_RESP_VALID && !MEM_RESP_ERROR);
endmodule // irrc_asserts

bind irrc_top irrc_asserts irrc_asserts_inst (.MCLK, .RST, .REQ_VALID, .REQ_READY, .REQ_DWORD,
  .REQ_ADDR, .REQ_DATA, .REMAP_ENABLED_STATUS, .EXTENDED_IRQ_MODE_ENABLE, .LEGACY_FORMAT_ALLOWED,
  .COHERENT, .TABLE_SIZE, .MEM_RD_VALID, .MEM_RD_ADDR, .MEM_RD_NO_SNOOP, .MEM_RESP_VALID,
  .MEM_RESP_ERROR, .OUT_VALID, .OUT_KIND, .OUT_TRIG_LEVEL, .FAULT_VALID, .FAULT_REASON,
  .FAULT_QUALIFIED);

// ### verif/irrc_mem_model.sv
// Behavioural table memory answering entry reads, prompt or slow
`timescale 1ns/100ps
module irrc_mem_model (
  input wire clk,
  input wire rst,
  input wire rd_valid,
  output reg rd_ready,
  output reg resp_valid,
  output reg resp_error,
  output wire [127:0] resp_data,
  input wire [127:0] entry,
  input wire err,
  input wire [3:0] slow,
  output reg [7:0] reads
);
  reg [3:0] cnt;
  reg pend;
  reg [127:0] last;
  // Idle data is the inverse of the last beat so stale data never passes for a reply
  assign resp_data = resp_valid ? last : ~last;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {rd_ready, resp_valid, resp_error, pend, cnt, reads, last} <= 144'h0;
    end
    else
    begin
      rd_ready <= 1'h0;
      resp_valid <= 1'h0;
      resp_error <= ~err;
      if (rd_valid && rd_ready)
      begin
        pend <= 1'h1;
        reads <= reads + 8'h1;
      end
      else if (pend)
      begin
        pend <= 1'h0;
        resp_valid <= 1'h1;
        resp_error <= err;
        last <= entry;
      end
      else if (rd_valid && cnt == slow)
      begin
        rd_ready <= 1'h1;
        cnt <= 4'h0;
      end
      else if (rd_valid)
        cnt <= cnt + 4'h1;
    end
  end
endmodule // irrc_mem_model

// ### verif/tb.sv
// Self-checking bench for the interrupt remap request checker
`timescale 1ns/100ps
module tb;
  reg mclk = 1'h0, rst = 1'h1, req_valid = 1'h0, dword = 1'h1, enabled = 1'h0, ext = 1'h0;
  reg leg_ok = 1'h1, coherent = 1'h1, flush = 1'h0, out_ready = 1'h0, mem_err = 1'h0;
  reg [31:0] addr = 32'h0, data = 32'h0;
  reg [15:0] rqid = 16'h0;
  reg [127:0] entry = 128'h0;
  reg [3:0] slow = 4'h0;
  wire req_ready, rd_valid, rd_ready, resp_valid, resp_error, out_valid, dmode, rhint, tmode;
  wire tlevel, f_valid, f_qual, no_snoop;
  wire [63:0] rd_addr;
  wire [1:0] kind;
  wire [2:0] dlv;
  wire [7:0] vec, f_reason, reads;
  wire [15:0] f_rqid, f_index;
  wire [31:0] o_addr, o_data, dest;
  wire [127:0] resp_data;
  integer mismatches = 0, total_checks = 0, lat = 0, res = 0, i;
  reg [48:0] ov;
  reg [63:0] oad;
  always #50 mclk = ~mclk;
  irrc_top irrc_top_inst (.MCLK(mclk), .RST(rst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_DWORD(dword), .REQ_ADDR(addr), .REQ_DATA(data), .REQ_REQUESTER_ID(rqid),
    .REMAP_ENABLED_STATUS(enabled), .EXTENDED_IRQ_MODE_ENABLE(ext),
    .LEGACY_FORMAT_ALLOWED(leg_ok), .COHERENT(coherent), .TABLE_SIZE(17'h40),
    .REMAP_TABLE_BASE(52'h1_2345), .CACHE_FLUSH(flush), .MEM_RD_VALID(rd_valid),
    .MEM_RD_READY(rd_ready), .MEM_RD_ADDR(rd_addr), .MEM_RD_NO_SNOOP(no_snoop),
    .MEM_RESP_VALID(resp_valid),
    .MEM_RESP_ERROR(resp_error), .MEM_RESP_DATA(resp_data), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_KIND(kind), .OUT_ADDR(o_addr), .OUT_DATA(o_data),
    .OUT_VECTOR(vec), .OUT_DEST(dest), .OUT_DELIVERY(dlv), .OUT_DEST_MODE(dmode),
    .OUT_REDIR_HINT(rhint), .OUT_TRIG_MODE(tmode), .OUT_TRIG_LEVEL(tlevel),
    .FAULT_VALID(f_valid), .FAULT_REASON(f_reason), .FAULT_QUALIFIED(f_qual),
    .FAULT_REQUESTER_ID(f_rqid), .FAULT_INDEX(f_index));
  irrc_mem_model irrc_mem_model_inst (.clk(mclk), .rst(rst), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .resp_valid(resp_valid), .resp_error(resp_error),
    .resp_data(resp_data), .entry(entry), .err(mem_err), .slow(slow), .reads(reads));
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [127:0] got, input [127:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
    end
  endtask
  // Remappable address; bits 1:0 set since they must be ignored
  function [31:0] ra(input [15:0] h, input sv);
    ra = {12'hFEE, h[14:0], 1'h1, sv, h[15], 2'h3};
  endfunction
  function [127:0] ent(input p, input frd, input [1:0] vt, input [1:0] qual, input [15:0] s,
    input rsv);
    ent = {rsv, 43'h0, vt, qual, s, 32'h0000_0034, 8'h0, 8'h5A, 8'h0, 3'h5, 3'h5, frd, p};
  endfunction
  // Ends on the answer: 0 output, 1 fault, 2 silent drop back to idle
  task run(input [31:0] a, input [31:0] d, input [15:0] s);
    begin
      @(posedge mclk);
      {req_valid, addr, data, rqid} <= {1'h1, a, d, s};
      @(negedge mclk);
      chk(req_ready, 1'h1);
      @(posedge mclk);
      req_valid <= 1'h0;
      lat = 0;
      res = 3;
      while (res == 3)
      begin
        @(negedge mclk);
        lat = lat + 1;
        if (out_valid === 1'h1)
          res = 0;
        else if (f_valid === 1'h1)
          res = 1;
        else if (req_ready === 1'h1)
          res = 2;
        else if (lat > 60)
        begin
          mismatches = mismatches + 1;
          $display("unexpected at %0t: no answer", $time);
          complete_run;
        end
      end
      ov = {kind, tlevel, vec, dest, dlv, dmode, rhint, tmode};
      oad = {o_addr, o_data};
      // Every answer ends on a rising edge so the next stimulus lands there too
      @(posedge mclk);
      out_ready <= (res == 0);
      @(posedge mclk);
      out_ready <= 1'h0;
    end
  endtask
  task expect_out(input [1:0] k, input [63:0] ad);
    chk({res[1:0], ov[48:46], oad}, {2'h0, k, 1'h0, ad});
  endtask
  task expect_fault(input [7:0] r, input q);
    chk({res[1:0], f_reason, f_qual}, {2'h1, r, q});
  endtask
  task expect_remap(input [127:0] e);
    chk({res[1:0], ov}, {2'h0, 2'h2, 1'h1, e[23:16], e[63:32], e[7:5], e[2], e[3], e[4]});
  endtask
  task try(input [15:0] x, input [127:0] e, input [15:0] s, input [7:0] r, input q);
    begin
      entry <= e;
      run(ra(x, 1'h0), 32'hDEAD_BEEF, s);
      if (r == 8'h0)
        expect_remap(e);
      else if (r == 8'hFF)
        chk(res[1:0], 2'h2);
      else
        expect_fault(r, q);
    end
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    run(32'hFEE0_0013, 32'h1234_5678, 16'h0);
    expect_out(2'h1, 64'hFEE0_0013_1234_5678);
    run(32'hFED0_0000, 32'h1, 16'h0);
    expect_out(2'h0, 64'hFED0_0000_0000_0001);
    dword <= 1'h0;
    run(32'hFEE0_0000, 32'h2, 16'h0);
    expect_out(2'h0, 64'hFEE0_0000_0000_0002);
    {dword, enabled} <= 2'h3;
    run(32'hFEE0_1008, 32'h3, 16'h0);
    expect_out(2'h1, 64'hFEE0_1008_0000_0003);
    for (i = 0; i < 3; i = i + 1)
    begin
      {ext, leg_ok} <= {i != 1, i == 2};
      run(32'hFEE0_0000, 32'h0, 16'h0);
      expect_fault(8'h25, 1'h0);
    end
    {ext, leg_ok} <= 2'h1;
    run(ra(16'h3, 1'h1), 32'h0001_0002, 16'h0ABC);
    expect_fault(8'h20, 1'h0);
    chk(f_rqid, 16'h0ABC);
    run(ra(16'h3C, 1'h1), 32'h0000_0004, 16'h0);
    expect_fault(8'h21, 1'h0);
    chk(f_index, 16'h40);
    try(16'h8000, 128'h0, 16'h0, 8'h21, 1'h0);
    chk(f_index, 16'h8000);
    {coherent, slow} <= {1'h0, 4'h3};
    entry <= ent(1'h1, 1'h0, 2'h0, 2'h0, 16'h0, 1'h0);
    run(ra(16'h14, 1'h1), 32'h0000_002B, 16'h0);
    expect_remap(ent(1'h1, 1'h0, 2'h0, 2'h0, 16'h0, 1'h0));
    chk({rd_addr, no_snoop}, {64'h0000_0000_1234_53F0, 1'h1});
    entry <= 128'h0;
    run(ra(16'h14, 1'h1), 32'h0000_002B, 16'h0);
    expect_remap(ent(1'h1, 1'h0, 2'h0, 2'h0, 16'h0, 1'h0));
    chk({lat, reads}, {32'h3, 8'h1});
    flush <= 1'h1;
    @(posedge mclk);
    {flush, coherent, slow} <= 6'h10;
    run(ra(16'h3F, 1'h0), 32'h0, 16'h0);
    expect_fault(8'h22, 1'h1);
    chk(no_snoop, 1'h0);
    chk(reads, 8'h2);
    try(16'h7, ent(1'h0, 1'h1, 2'h0, 2'h0, 16'h0, 1'h0), 16'h0, 8'hFF, 1'h0);
    mem_err <= 1'h1;
    try(16'h8, ent(1'h1, 1'h0, 2'h0, 2'h0, 16'h0, 1'h0), 16'h0, 8'h23, 1'h0);
    mem_err <= 1'h0;
    try(16'h9, ent(1'h1, 1'h0, 2'h0, 2'h0, 16'h0, 1'h1), 16'h0, 8'h24, 1'h1);
    try(16'hA, ent(1'h1, 1'h1, 2'h0, 2'h0, 16'h0, 1'h1), 16'h0, 8'hFF, 1'h0);
    try(16'hB, ent(1'h1, 1'h0, 2'h3, 2'h0, 16'h0, 1'h0), 16'h0, 8'h24, 1'h1);
    try(16'hC, ent(1'h1, 1'h0, 2'h1, 2'h0, 16'h0123, 1'h0), 16'h0127, 8'h26, 1'h1);
    try(16'hD, ent(1'h1, 1'h0, 2'h1, 2'h1, 16'h0123, 1'h0), 16'h0127, 8'h0, 1'h0);
    try(16'hE, ent(1'h1, 1'h0, 2'h2, 2'h0, 16'h1020, 1'h0), 16'h2100, 8'h26, 1'h1);
    try(16'h1E, ent(1'h1, 1'h0, 2'h2, 2'h0, 16'h1020, 1'h0), 16'h1500, 8'h0, 1'h0);
    complete_run;
  end
endmodule // tb

// ### verilog/irrc_decode.v
// Field decode and index arithmetic for a remappable interrupt request
`timescale 1ns/100ps
`include "irrc_regs.vh"

module irrc_decode (
  input wire [31:0] addr,
  input wire [31:0] data,
  output wire in_window,
  output wire fmt_remap,
  output wire subhandle_valid,
  output wire [15:0] handle,
  output wire [15:0] subhandle,
  output wire rsvd_bad,
  output wire [16:0] index
);

  assign in_window = (addr[`IRRC_ADDR_ID_HI:`IRRC_ADDR_ID_LO] == `IRRC_IRQ_WINDOW_ID);
  assign fmt_remap = addr[`IRRC_ADDR_FORMAT];
  assign subhandle_valid = addr[`IRRC_ADDR_SUB_VALID];
  assign handle = {addr[`IRRC_ADDR_HANDLE15], addr[`IRRC_ADDR_HANDLE_HI:`IRRC_ADDR_HANDLE_LO]};
  assign subhandle = data[`IRRC_DATA_SUB_HI:`IRRC_DATA_SUB_LO];
  // Upper data bits matter only when a subhandle is carried
  assign rsvd_bad = subhandle_valid &&
    (data[`IRRC_DATA_RSVD_HI:`IRRC_DATA_RSVD_LO] != 16'h0000);
  // 17-bit sum so a wrapped handle plus subhandle still fails the bounds check
  assign index = subhandle_valid ? ({1'b0, handle} + {1'b0, subhandle})
                                 : {1'b0, handle};

endmodule // irrc_decode

// ### verilog/irrc_entry_cache.v
// Direct-mapped cache of remap table entries with registered read data
`timescale 1ns/100ps
`include "irrc_regs.vh"

module irrc_entry_cache (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire rd_en,
  input wire [15:0] rd_idx,
  output reg rd_hit,
  output reg [127:0] rd_entry,
  input wire wr_en,
  input wire [15:0] wr_idx,
  input wire [127:0] wr_entry
);

  reg [127:0] mem [0:`IRRC_CACHE_DEPTH-1];
  reg [15-`IRRC_CACHE_SLOT_BITS:0] tag [0:`IRRC_CACHE_DEPTH-1];
  reg [`IRRC_CACHE_DEPTH-1:0] valid;
  wire [`IRRC_CACHE_SLOT_BITS-1:0] rd_slot = rd_idx[`IRRC_CACHE_SLOT_BITS-1:0];
  wire [`IRRC_CACHE_SLOT_BITS-1:0] wr_slot = wr_idx[`IRRC_CACHE_SLOT_BITS-1:0];

  // Flush beats a same-cycle fill so a stale entry never survives invalidation
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      valid <= {`IRRC_CACHE_DEPTH{1'b0}};
    else if (flush)
      valid <= {`IRRC_CACHE_DEPTH{1'b0}};
    else if (wr_en)
      valid[wr_slot] <= 1'b1;
  end

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_slot] <= wr_entry;
      tag[wr_slot] <= wr_idx[15:`IRRC_CACHE_SLOT_BITS];
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_hit <= 1'b0;
      rd_entry <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
    end
    else if (rd_en)
    begin
      rd_hit <= valid[rd_slot] && !flush &&
        (tag[rd_slot] == rd_idx[15:`IRRC_CACHE_SLOT_BITS]);
      rd_entry <= mem[rd_slot];
    end
  end

endmodule // irrc_entry_cache

// ### verilog/irrc_top.v
// Interrupt remap request checker: classify, check, fetch entry, remap or fault
//
// Function
// - Dword writes to FEE window are interrupt requests
// - Remapping off means legacy handling, no remap
// - Block legacy format if extended mode or disallowed
// - Otherwise pass legacy format through unchanged
// - Nonzero request reserved bits fault 20h
// - Index not below table size faults 21h
// - Entry comes from cache or memory table
// - Non-coherent unit reads table without snooping
// - Table read error faults 23h
// - Entry not present faults 22h, qualified
// - Badly programmed entry faults 24h, qualified
// - Requester identity mismatch faults 26h, qualified
// - Blocked legacy format reports fault 25h
// - Passing request emits remapped interrupt from entry
// - Remapped interrupt trigger level always asserted
// - Qualified faults reported only if not disabled
// - Address holds id, handle, format, subhandle flag
// - Index is handle, plus subhandle when valid
// - Subhandle data upper half must be zero
// - Table entries are 128 bits, up to 64K
`timescale 1ns/100ps
`include "irrc_regs.vh"

module irrc_top (
  input wire MCLK,
  input wire RST,
  input wire REQ_VALID,
  output wire REQ_READY,
  input wire REQ_DWORD,
  input wire [31:0] REQ_ADDR,
  input wire [31:0] REQ_DATA,
  input wire [15:0] REQ_REQUESTER_ID,
  input wire REMAP_ENABLED_STATUS,
  input wire EXTENDED_IRQ_MODE_ENABLE,
  input wire LEGACY_FORMAT_ALLOWED,
  input wire COHERENT,
  input wire [16:0] TABLE_SIZE,
  input wire [63:12] REMAP_TABLE_BASE,
  input wire CACHE_FLUSH,
  output wire MEM_RD_VALID,
  input wire MEM_RD_READY,
  output reg [63:0] MEM_RD_ADDR,
  output reg MEM_RD_NO_SNOOP,
  input wire MEM_RESP_VALID,
  input wire MEM_RESP_ERROR,
  input wire [127:0] MEM_RESP_DATA,
  output wire OUT_VALID,
  input wire OUT_READY,
  output reg [1:0] OUT_KIND,
  output reg [31:0] OUT_ADDR,
  output reg [31:0] OUT_DATA,
  output reg [7:0] OUT_VECTOR,
  output reg [31:0] OUT_DEST,
  output reg [2:0] OUT_DELIVERY,
  output reg OUT_DEST_MODE,
  output reg OUT_REDIR_HINT,
  output reg OUT_TRIG_MODE,
  output reg OUT_TRIG_LEVEL,
  output reg FAULT_VALID,
  output reg [7:0] FAULT_REASON,
  output reg FAULT_QUALIFIED,
  output reg [15:0] FAULT_REQUESTER_ID,
  output reg [15:0] FAULT_INDEX
);

  localparam [6:0] S_IDLE = 7'b000_0001;
  localparam [6:0] S_LOOK = 7'b000_0010;
  localparam [6:0] S_FETCH = 7'b000_0100;
  localparam [6:0] S_WAIT = 7'b000_1000;
  localparam [6:0] S_CHECK = 7'b001_0000;
  localparam [6:0] S_EMIT = 7'b010_0000;
  localparam [6:0] S_FAULT = 7'b100_0000;

  reg [6:0] state;
  reg [6:0] next_state;
  reg [15:0] req_requester_id;
  reg [15:0] req_index;
  reg [127:0] entry;
  reg ext_mode;

  wire in_window;
  wire fmt_remap;
  wire sub_valid;
  wire [15:0] handle;
  wire [15:0] subhandle;
  wire req_rsvd_bad;
  wire [16:0] index;
  wire cache_hit;
  wire [127:0] cache_entry;

  wire accept = REQ_VALID && (state == S_IDLE);
  wire resp_take = (state == S_WAIT) && MEM_RESP_VALID;

  assign REQ_READY = (state == S_IDLE);
  assign MEM_RD_VALID = (state == S_FETCH);
  assign OUT_VALID = (state == S_EMIT);

  irrc_decode u_decode (
    .addr(REQ_ADDR),
    .data(REQ_DATA),
    .in_window(in_window),
    .fmt_remap(fmt_remap),
    .subhandle_valid(sub_valid),
    .handle(handle),
    .subhandle(subhandle),
    .rsvd_bad(req_rsvd_bad),
    .index(index)
  );

  // Only error-free fetches are cached, so a bad read is retried next time
  irrc_entry_cache u_cache (
    .clk(MCLK),
    .rst(RST),
    .flush(CACHE_FLUSH),
    .rd_en(accept),
    .rd_idx(index[15:0]),
    .rd_hit(cache_hit),
    .rd_entry(cache_entry),
    .wr_en(resp_take && !MEM_RESP_ERROR),
    .wr_idx(req_index),
    .wr_entry(MEM_RESP_DATA)
  );

  // Table address of a 128-bit entry: base plus index times 16 bytes
  function [63:0] entry_addr;
    input [63:12] base;
    input [15:0] idx;
    begin
      entry_addr = {base, 12'h000} + {44'h000_0000_0000, idx, 4'h0};
    end
  endfunction

  // Reserved and conditionally reserved entry fields
  function entry_bad;
    input [127:0] e;
    input ext;
    begin
      entry_bad = (e[`IRRC_E_RSVD0_HI:`IRRC_E_RSVD0_LO] != 4'h0) ||
        (e[`IRRC_E_RSVD1_HI:`IRRC_E_RSVD1_LO] != 8'h00) ||
        (e[`IRRC_E_RSVD2_HI:`IRRC_E_RSVD2_LO] != 44'h000_0000_0000) ||
        (e[`IRRC_E_VERIFY_HI:`IRRC_E_VERIFY_LO] == 2'h3) ||
        (e[`IRRC_E_VERIFY_HI:`IRRC_E_VERIFY_LO] != `IRRC_VERIFY_ID &&
         e[`IRRC_E_QUAL_HI:`IRRC_E_QUAL_LO] != 2'h0) ||
        (!ext && e[`IRRC_E_DEST_HI:`IRRC_E_DEST_LO+16] != 16'h0000);
    end
  endfunction

  // Requester identity check; qualifier masks function bits from bit 2 down
  function requester_ok;
    input [127:0] e;
    input [15:0] rid;
    reg [15:0] exp;
    reg [15:0] mask;
    begin
      exp = e[`IRRC_E_EXP_ID_HI:`IRRC_E_EXP_ID_LO];
      case (e[`IRRC_E_QUAL_HI:`IRRC_E_QUAL_LO])
        2'h1: mask = 16'hFFFB;
        2'h2: mask = 16'hFFF9;
        2'h3: mask = 16'hFFF8;
        default: mask = 16'hFFFF;
      endcase
      case (e[`IRRC_E_VERIFY_HI:`IRRC_E_VERIFY_LO])
        `IRRC_VERIFY_NONE: requester_ok = 1'b1;
        `IRRC_VERIFY_ID: requester_ok = ((rid & mask) == (exp & mask));
        `IRRC_VERIFY_BUS: requester_ok = (rid[15:8] >= exp[15:8]) && (rid[15:8] <= exp[7:0]);
        default: requester_ok = 1'b0;
      endcase
    end
  endfunction

  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (REQ_VALID)
        begin
          if (!in_window || !REQ_DWORD || !REMAP_ENABLED_STATUS)
            next_state = S_EMIT;
          else if (!fmt_remap)
            next_state = (EXTENDED_IRQ_MODE_ENABLE || !LEGACY_FORMAT_ALLOWED) ?
              S_FAULT : S_EMIT;
          else if (req_rsvd_bad || index >= TABLE_SIZE)
            next_state = S_FAULT;
          else
            next_state = S_LOOK;
        end
      end
      S_LOOK:
        next_state = cache_hit ? S_CHECK : S_FETCH;
      S_FETCH:
        if (MEM_RD_READY)
          next_state = S_WAIT;
      S_WAIT:
        if (MEM_RESP_VALID)
          next_state = MEM_RESP_ERROR ? S_FAULT : S_CHECK;
      S_CHECK:
      begin
        if (!entry[`IRRC_E_PRESENT] || entry_bad(entry, ext_mode) ||
            !requester_ok(entry, req_requester_id))
          // Qualified fault with reporting disabled is silently dropped
          next_state = entry[`IRRC_E_FAULT_DIS] ? S_IDLE : S_FAULT;
        else
          next_state = S_EMIT;
      end
      S_EMIT:
        if (OUT_READY)
          next_state = S_IDLE;
      S_FAULT:
        next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
  end

  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // Request capture and entry holding
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      req_requester_id <= 16'h0000;
      req_index <= 16'h0000;
      entry <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      ext_mode <= 1'b0;
      MEM_RD_ADDR <= 64'h0000_0000_0000_0000;
      MEM_RD_NO_SNOOP <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        req_requester_id <= REQ_REQUESTER_ID;
        req_index <= index[15:0];
        ext_mode <= EXTENDED_IRQ_MODE_ENABLE;
        MEM_RD_ADDR <= entry_addr(REMAP_TABLE_BASE, index[15:0]);
        MEM_RD_NO_SNOOP <= !COHERENT;
      end
      if (state == S_LOOK && cache_hit)
        entry <= cache_entry;
      else if (resp_take && !MEM_RESP_ERROR)
        entry <= MEM_RESP_DATA;
    end
  end

  // Emitted request; pass-through keeps address and data unchanged
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      OUT_KIND <= `IRRC_KIND_OTHER;
      OUT_ADDR <= 32'h0000_0000;
      OUT_DATA <= 32'h0000_0000;
      OUT_VECTOR <= 8'h00;
      OUT_DEST <= 32'h0000_0000;
      OUT_DELIVERY <= 3'h0;
      OUT_DEST_MODE <= 1'b0;
      OUT_REDIR_HINT <= 1'b0;
      OUT_TRIG_MODE <= 1'b0;
      OUT_TRIG_LEVEL <= 1'b0;
    end
    else if (accept)
    begin
      OUT_ADDR <= REQ_ADDR;
      OUT_DATA <= REQ_DATA;
      OUT_TRIG_LEVEL <= 1'b0;
      if (in_window && REQ_DWORD)
        OUT_KIND <= `IRRC_KIND_LEGACY;
      else
        OUT_KIND <= `IRRC_KIND_OTHER;
    end
    else if (state == S_CHECK)
    begin
      OUT_KIND <= `IRRC_KIND_REMAP;
      OUT_VECTOR <= entry[`IRRC_E_VEC_HI:`IRRC_E_VEC_LO];
      OUT_DEST <= entry[`IRRC_E_DEST_HI:`IRRC_E_DEST_LO];
      OUT_DELIVERY <= entry[`IRRC_E_DLV_HI:`IRRC_E_DLV_LO];
      OUT_DEST_MODE <= entry[`IRRC_E_DST_MODE];
      OUT_REDIR_HINT <= entry[`IRRC_E_REDIR_HINT];
      OUT_TRIG_MODE <= entry[`IRRC_E_TRIG_MODE];
      OUT_TRIG_LEVEL <= 1'b1;
    end
  end

  // Fault report: one-cycle pulse, fields reloaded on every accepted request and updated on every entry check or a failed read
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      FAULT_VALID <= 1'b0;
      FAULT_REASON <= 8'h00;
      FAULT_QUALIFIED <= 1'b0;
      FAULT_REQUESTER_ID <= 16'h0000;
      FAULT_INDEX <= 16'h0000;
    end
    else
    begin
      FAULT_VALID <= (next_state == S_FAULT);
      if (accept)
      begin
        FAULT_REQUESTER_ID <= REQ_REQUESTER_ID;
        FAULT_INDEX <= index[15:0];
        FAULT_QUALIFIED <= 1'b0;
        if (!fmt_remap)
          FAULT_REASON <= `IRRC_FR_LEGACY_BLOCK;
        else if (req_rsvd_bad)
          FAULT_REASON <= `IRRC_FR_REQ_RSVD;
        else
          FAULT_REASON <= `IRRC_FR_BOUNDS;
      end
      else if (resp_take && MEM_RESP_ERROR)
        FAULT_REASON <= `IRRC_FR_TABLE_ERR;
      else if (state == S_CHECK)
      begin
        FAULT_QUALIFIED <= 1'b1;
        if (!entry[`IRRC_E_PRESENT])
          FAULT_REASON <= `IRRC_FR_NOT_PRESENT;
        else if (entry_bad(entry, ext_mode))
          FAULT_REASON <= `IRRC_FR_ENTRY_RSVD;
        else
          FAULT_REASON <= `IRRC_FR_ID_FAIL;
      end
    end
  end

endmodule // irrc_top
